// file: common/brnc_cfg.svh
`ifndef BRNC_CFG_SVH
`define BRNC_CFG_SVH

// ****************************************
// register map, byte addresses
// ****************************************
`define BRNC_ADDR_CTRL      8'h00
`define BRNC_ADDR_SRC       8'h04
`define BRNC_ADDR_STAT      8'h08
`define BRNC_ADDR_IEN       8'h0c

// ****************************************
// control register fields and reset values
// ****************************************
`define BRNC_CTRL_MASK_BIT  0
`define BRNC_CTRL_CLRN_BIT  1
`define BRNC_CTRL_RST       2'h3

// ****************************************
// event bits of status and enable
// ****************************************
`define BRNC_EV_UART        0
`define BRNC_EV_NMI_TP      1
`define BRNC_EV_HOST_NMI    2
`define BRNC_EV_TIMEOUT     3
`define BRNC_EV_RST_TP      4
`define BRNC_EV_RST_BTN     5
`define BRNC_EV_RST_HOST    6
`define BRNC_EV_POR         7
`define BRNC_EV_W           8
`define BRNC_SRC_NMI_BIT    4

// ****************************************
// pin vector layout and idle levels
// ****************************************
`define BRNC_PIN_RST_TP_N   0
`define BRNC_PIN_BTN_N      1
`define BRNC_PIN_HOST_RST   2
`define BRNC_PIN_UART_N     3
`define BRNC_PIN_NMI_TP_N   4
`define BRNC_PIN_HOST_NMI   5
`define BRNC_PIN_BUSY       6
`define BRNC_PIN_W          7
`define BRNC_PIN_IDLE       7'h1b

// ****************************************
// timing
// ****************************************
`define BRNC_CLK_PERIOD_NS  4
`define BRNC_POR_NS         1000
`define BRNC_POR_CYCLES     ((`BRNC_POR_NS + `BRNC_CLK_PERIOD_NS - 1) / `BRNC_CLK_PERIOD_NS)
`define BRNC_POR_CW         8
`define BRNC_BTO_CYCLES     30
`define BRNC_BTO_CW         5
`define BRNC_BUS_DIV        4
`define BRNC_DIV_CW         4

`endif

// file: common/brnc_pkg.sv
`include "brnc_cfg.svh"

package brnc_pkg;

    typedef struct packed {
        logic [`BRNC_PIN_W-1:0]  s1;
        logic [`BRNC_PIN_W-1:0]  s2;
        logic [`BRNC_PIN_W-1:0]  s3;
        logic [`BRNC_PIN_W-1:0]  pin;
        logic [`BRNC_POR_CW-1:0] por_cnt;
        logic                    por_act;
        logic [`BRNC_DIV_CW-1:0] div_cnt;
        logic [`BRNC_BTO_CW-1:0] bto_cnt;
        logic                    bto_flag_n;
        logic                    clr_prev;
        logic                    mask;
        logic                    clear_n;
        logic [`BRNC_EV_W-1:0]   stat;
        logic [`BRNC_EV_W-1:0]   ien;
        logic [31:0]             rdata;
        logic                    cpu_rst_n;
        logic                    sys_rst_n;
        logic                    nmi_n;
        logic                    irq;
    } brnc_state_type;

endpackage

// file: verilog/brnc_top.sv
// Operation
// - the cpu reset is active while power-on, test pin, push button or host reset is active.
// - every source that resets the cpu also drives the board system reset at the same time.
// - a power-on reset pulse is produced by itself after board power comes up.
// - the reset test pin, when asserted, resets the cpu and the board.
// - the rear push button, when pressed, resets the cpu and the board.
// - a host reset request from the isa side resets the cpu and the board.
// - an active uart interrupt output raises the urgent interrupt unless masked.
// - the urgent interrupt test pin is one more source of the urgent interrupt.
// - a host urgent request for communication is passed on, subject to the mask.
// - while the gate mask bit is 1 no urgent source reaches the cpu.
// - reset and urgent interrupt are driven to the cpu as active-low levels.
// - the gate mask blocks at a gate when 1 and is set to 1 by any reset.
// - the active-low timeout flag drops after a bus access runs 30 bus cycles.
// - the timeout flag returns to 1 after the clear bit goes 0 and back to 1, or on any reset.
//
// The register addresses and the strobed register port were left to the implementer.

`timescale 1ns/1ps
`default_nettype none

`include "brnc_cfg.svh"

module brnc_top #(
    parameter int POR_CYCLES = `BRNC_POR_CYCLES,
    parameter int BUS_DIV    = `BRNC_BUS_DIV
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        reset_test_n,
    input  wire logic        push_button_reset_n,
    input  wire logic        host_reset_req,
    input  wire logic        uart_irq_request_n,
    input  wire logic        nmi_test_n,
    input  wire logic        host_nmi_req,
    input  wire logic        bus_access_busy,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             cpu_reset_n,
    output logic             sys_reset_n,
    output logic             cpu_nmi_n,
    output logic             bus_timeout_flag_n,
    output logic             irq
);

    // ****************************************
    // reset release
    // ****************************************
    logic       rst_s1_ff;
    logic       rst_s2_ff;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    // a pin only changes once the second and third stages agree
    function automatic logic [`BRNC_PIN_W-1:0] settle(
        input logic [`BRNC_PIN_W-1:0] cur,
        input logic [`BRNC_PIN_W-1:0] b,
        input logic [`BRNC_PIN_W-1:0] c
    );
        logic [`BRNC_PIN_W-1:0] r;
        r = cur;
        for (int i = 0; i < `BRNC_PIN_W; i++) begin
            if (b[i] == c[i]) begin
                r[i] = c[i];
            end
        end
        return r;
    endfunction

    function automatic logic hit(
        input logic [7:0] a,
        input logic [7:0] want
    );
        return a == want;
    endfunction

    // ****************************************
    // state
    // ****************************************
    brnc_pkg::brnc_state_type st_ff;
    brnc_pkg::brnc_state_type nxt_st;

    logic [`BRNC_PIN_W-1:0]  raw_pins;
    logic                    src_rst_tp;
    logic                    src_rst_btn;
    logic                    src_rst_host;
    logic                    src_uart;
    logic                    src_nmi_tp;
    logic                    src_host_nmi;
    logic                    src_bto;
    logic                    busy;
    logic                    rst_any;
    logic                    nmi_any;
    logic                    bus_tick;
    logic [`BRNC_EV_W-1:0]   events;
    logic [`BRNC_BTO_CW-1:0] bto_inc;

    always_comb begin
        raw_pins = '0;
        raw_pins[`BRNC_PIN_RST_TP_N] = reset_test_n;
        raw_pins[`BRNC_PIN_BTN_N]    = push_button_reset_n;
        raw_pins[`BRNC_PIN_HOST_RST] = host_reset_req;
        raw_pins[`BRNC_PIN_UART_N]   = uart_irq_request_n;
        raw_pins[`BRNC_PIN_NMI_TP_N] = nmi_test_n;
        raw_pins[`BRNC_PIN_HOST_NMI] = host_nmi_req;
        raw_pins[`BRNC_PIN_BUSY]     = bus_access_busy;
    end

    always_comb begin
        nxt_st = st_ff;

        // ****************************************
        // pin synchronisers
        // ****************************************
        nxt_st.s1  = raw_pins;
        nxt_st.s2  = st_ff.s1;
        nxt_st.s3  = st_ff.s2;
        nxt_st.pin = settle(st_ff.pin, st_ff.s2, st_ff.s3);

        src_rst_tp   = !st_ff.pin[`BRNC_PIN_RST_TP_N];
        src_rst_btn  = !st_ff.pin[`BRNC_PIN_BTN_N];
        src_rst_host = st_ff.pin[`BRNC_PIN_HOST_RST];
        src_uart     = !st_ff.pin[`BRNC_PIN_UART_N];
        src_nmi_tp   = !st_ff.pin[`BRNC_PIN_NMI_TP_N];
        src_host_nmi = st_ff.pin[`BRNC_PIN_HOST_NMI];
        busy         = st_ff.pin[`BRNC_PIN_BUSY];
        src_bto      = !st_ff.bto_flag_n;

        // ****************************************
        // power-on stretch
        // ****************************************
        // counts after the reset release so the cpu sees a clean pulse
        if (st_ff.por_act) begin
            if (st_ff.por_cnt == `BRNC_POR_CW'(POR_CYCLES - 1)) begin
                nxt_st.por_act = 1'b0;
            end else begin
                nxt_st.por_cnt = st_ff.por_cnt + `BRNC_POR_CW'(1);
            end
        end

        rst_any = st_ff.por_act | src_rst_tp | src_rst_btn | src_rst_host;

        // ****************************************
        // bus cycle divider
        // ****************************************
        bus_tick = 1'b0;
        if (st_ff.div_cnt == `BRNC_DIV_CW'(BUS_DIV - 1)) begin
            nxt_st.div_cnt = '0;
            bus_tick       = 1'b1;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + `BRNC_DIV_CW'(1);
        end

        // ****************************************
        // register writes
        // ****************************************
        if (reg_wr) begin
            if (hit(reg_addr, `BRNC_ADDR_CTRL)) begin
                nxt_st.mask    = reg_wdata[`BRNC_CTRL_MASK_BIT];
                nxt_st.clear_n = reg_wdata[`BRNC_CTRL_CLRN_BIT];
            end else if (hit(reg_addr, `BRNC_ADDR_STAT)) begin
                nxt_st.stat = st_ff.stat & ~reg_wdata[`BRNC_EV_W-1:0];
            end else if (hit(reg_addr, `BRNC_ADDR_IEN)) begin
                nxt_st.ien = reg_wdata[`BRNC_EV_W-1:0];
            end
        end

        // ****************************************
        // bus timeout flag
        // ****************************************
        nxt_st.clr_prev = st_ff.clear_n;
        bto_inc = st_ff.bto_cnt + `BRNC_BTO_CW'(1);
        if (!st_ff.clr_prev && st_ff.clear_n) begin
            nxt_st.bto_flag_n = 1'b1;
            nxt_st.bto_cnt    = '0;
        end
        if (!busy) begin
            nxt_st.bto_cnt = '0;
        end else if (bus_tick && st_ff.bto_flag_n) begin
            nxt_st.bto_cnt = bto_inc;
            if (bto_inc >= `BRNC_BTO_CW'(`BRNC_BTO_CYCLES)) begin
                nxt_st.bto_flag_n = 1'b0;
                nxt_st.bto_cnt    = '0;
            end
        end

        // ****************************************
        // board reset of control state
        // ****************************************
        if (rst_any) begin
            nxt_st.mask       = 1'b1;
            nxt_st.clear_n    = 1'b1;
            nxt_st.clr_prev   = 1'b1;
            nxt_st.bto_flag_n = 1'b1;
            nxt_st.bto_cnt    = '0;
        end

        // ****************************************
        // urgent interrupt combine
        // ****************************************
        // the mask acts on the live or, so a source that stays up reappears on unmask
        nmi_any = src_uart | src_nmi_tp | src_host_nmi | src_bto;
        nxt_st.nmi_n = !(nmi_any && !st_ff.mask);

        nxt_st.cpu_rst_n = !rst_any;
        nxt_st.sys_rst_n = !rst_any;

        // ****************************************
        // sticky events, set beats clear
        // ****************************************
        events = '0;
        events[`BRNC_EV_UART]     = src_uart;
        events[`BRNC_EV_NMI_TP]   = src_nmi_tp;
        events[`BRNC_EV_HOST_NMI] = src_host_nmi;
        events[`BRNC_EV_TIMEOUT]  = src_bto;
        events[`BRNC_EV_RST_TP]   = src_rst_tp;
        events[`BRNC_EV_RST_BTN]  = src_rst_btn;
        events[`BRNC_EV_RST_HOST] = src_rst_host;
        events[`BRNC_EV_POR]      = st_ff.por_act;
        nxt_st.stat = nxt_st.stat | events;
        nxt_st.irq  = |(nxt_st.stat & nxt_st.ien);

        // ****************************************
        // register reads
        // ****************************************
        nxt_st.rdata = '0;
        if (reg_rd) begin
            if (hit(reg_addr, `BRNC_ADDR_CTRL)) begin
                nxt_st.rdata[`BRNC_CTRL_MASK_BIT] = st_ff.mask;
                nxt_st.rdata[`BRNC_CTRL_CLRN_BIT] = st_ff.clear_n;
            end else if (hit(reg_addr, `BRNC_ADDR_SRC)) begin
                nxt_st.rdata[`BRNC_EV_UART]     = src_uart;
                nxt_st.rdata[`BRNC_EV_NMI_TP]   = src_nmi_tp;
                nxt_st.rdata[`BRNC_EV_HOST_NMI] = src_host_nmi;
                nxt_st.rdata[`BRNC_EV_TIMEOUT]  = src_bto;
                nxt_st.rdata[`BRNC_SRC_NMI_BIT] = !st_ff.nmi_n;
            end else if (hit(reg_addr, `BRNC_ADDR_STAT)) begin
                nxt_st.rdata[`BRNC_EV_W-1:0] = st_ff.stat;
            end else if (hit(reg_addr, `BRNC_ADDR_IEN)) begin
                nxt_st.rdata[`BRNC_EV_W-1:0] = st_ff.ien;
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            st_ff            <= '0;
            st_ff.s1         <= `BRNC_PIN_IDLE;
            st_ff.s2         <= `BRNC_PIN_IDLE;
            st_ff.s3         <= `BRNC_PIN_IDLE;
            st_ff.pin        <= `BRNC_PIN_IDLE;
            st_ff.por_act    <= 1'b1;
            st_ff.bto_flag_n <= 1'b1;
            st_ff.clr_prev   <= 1'b1;
            st_ff.mask       <= 1'(`BRNC_CTRL_RST >> `BRNC_CTRL_MASK_BIT);
            st_ff.clear_n    <= 1'b1;
            st_ff.nmi_n      <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata          = st_ff.rdata;
    assign cpu_reset_n        = st_ff.cpu_rst_n;
    assign sys_reset_n        = st_ff.sys_rst_n;
    assign cpu_nmi_n          = st_ff.nmi_n;
    assign bus_timeout_flag_n = st_ff.bto_flag_n;
    assign irq                = st_ff.irq;

endmodule

`default_nettype wire

// file: bench/brnc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "brnc_cfg.svh"

module brnc_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        cpu_reset_n,
    input  wire logic        cpu_nmi_n,
    input  wire logic [31:0] reg_rdata,
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    int nmi_cnt;

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        nmi_cnt   = 0;
    end

    // both inputs are active low
    always @(negedge cpu_nmi_n) if (cpu_reset_n) nmi_cnt++;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // handler entry: gate closed first so a second event cannot nest
    task automatic service(output logic [31:0] st);
        wr(`BRNC_ADDR_CTRL, 32'h0000_0003);
        rd(`BRNC_ADDR_STAT, st);
        wr(`BRNC_ADDR_STAT, st);
    endtask
endmodule

`default_nettype wire

// file: bench/brnc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module brnc_top_asserts #(
    parameter int BUS_DIV = 4
) (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        reset_test_n,
    input wire logic        push_button_reset_n,
    input wire logic        host_reset_req,
    input wire logic        uart_irq_request_n,
    input wire logic        nmi_test_n,
    input wire logic        host_nmi_req,
    input wire logic        bus_access_busy,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        cpu_reset_n,
    input wire logic        sys_reset_n,
    input wire logic        cpu_nmi_n,
    input wire logic        bus_timeout_flag_n,
    input wire logic        irq
);
    // margin covers pin sync and the registered flag
    localparam int TMO = 30 * BUS_DIV + 8;
    logic       mask_ff;
    logic [7:0] busy_ff;
    logic [3:0] age_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_ff <= 1'b1;
            busy_ff <= 8'h00;
            age_ff  <= 4'hf;
        end else begin
            if (!cpu_reset_n) mask_ff <= 1'b1;
            else if (reg_wr && reg_addr == 8'h00) mask_ff <= reg_wdata[0];
            busy_ff <= bus_access_busy ? busy_ff + 8'(busy_ff != 8'hff) : 8'h00;
            if (reg_wr && reg_addr == 8'h00 && reg_wdata[1]) age_ff <= 4'h0;
            else if (age_ff != 4'hf) age_ff <= age_ff + 4'h1;
        end
    end

    property p_pair; sys_reset_n == cpu_reset_n; endproperty
    a_pair: assert property (p_pair) else $error("reset outputs differ");
    property p_por; $rose(rst_b) |-> !cpu_reset_n [*5]; endproperty
    a_por: assert property (p_por) else $error("power-on reset too short");
    property p_rst;
        (!reset_test_n || !push_button_reset_n || host_reset_req) [*8] |-> !cpu_reset_n;
    endproperty
    a_rst: assert property (p_rst) else $error("reset source ignored");
    property p_mask; mask_ff && $past(mask_ff) |-> cpu_nmi_n; endproperty
    a_mask: assert property (p_mask) else $error("urgent irq passed the mask");
    property p_uart;
        !uart_irq_request_n [*8] ##0 (!mask_ff && !$past(mask_ff)) |-> !cpu_nmi_n;
    endproperty
    a_uart: assert property (p_uart) else $error("uart urgent irq lost");
    property p_level;
        (uart_irq_request_n && nmi_test_n && !host_nmi_req && bus_timeout_flag_n) [*8]
            |-> cpu_nmi_n;
    endproperty
    a_level: assert property (p_level) else $error("urgent irq without source");
    property p_tmo; busy_ff >= TMO && cpu_reset_n |-> !bus_timeout_flag_n; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout flag not set");
    property p_clr; $rose(bus_timeout_flag_n) |-> age_ff <= 4'h4 || !$past(cpu_reset_n); endproperty
    a_clr: assert property (p_clr) else $error("timeout flag cleared by itself");

    c_nmi: cover property ($fell(cpu_nmi_n));
    c_rst: cover property ($fell(cpu_reset_n));
    c_tmo: cover property ($fell(bus_timeout_flag_n));
endmodule

bind brnc_top brnc_top_asserts #(.BUS_DIV(BUS_DIV)) brnc_top_asserts_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .reset_test_n(reset_test_n),
    .push_button_reset_n(push_button_reset_n), .host_reset_req(host_reset_req),
    .uart_irq_request_n(uart_irq_request_n), .nmi_test_n(nmi_test_n),
    .host_nmi_req(host_nmi_req), .bus_access_busy(bus_access_busy), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_reset_n(cpu_reset_n), .sys_reset_n(sys_reset_n), .cpu_nmi_n(cpu_nmi_n),
    .bus_timeout_flag_n(bus_timeout_flag_n), .irq(irq)
);

`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "brnc_cfg.svh"

module tb_top;
    logic        sys_clk, rst_b, reset_test_n, push_button_reset_n, host_reset_req;
    logic        uart_irq_request_n, nmi_test_n, host_nmi_req, bus_access_busy;
    logic        reg_wr, reg_rd, cpu_reset_n, sys_reset_n, cpu_nmi_n, bus_timeout_flag_n, irq;
    logic [7:0]  reg_addr, ien;
    logic [31:0] reg_wdata, reg_rdata, rv;
    int          fails, tests_run, cyc, k, sb;

    brnc_top #(.POR_CYCLES(4), .BUS_DIV(1)) brnc_top_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .reset_test_n(reset_test_n),
        .push_button_reset_n(push_button_reset_n), .host_reset_req(host_reset_req),
        .uart_irq_request_n(uart_irq_request_n), .nmi_test_n(nmi_test_n),
        .host_nmi_req(host_nmi_req), .bus_access_busy(bus_access_busy), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_reset_n(cpu_reset_n), .sys_reset_n(sys_reset_n), .cpu_nmi_n(cpu_nmi_n),
        .bus_timeout_flag_n(bus_timeout_flag_n), .irq(irq));
    brnc_cpu_model brnc_cpu_model_inst (.sys_clk(sys_clk), .cpu_reset_n(cpu_reset_n),
        .cpu_nmi_n(cpu_nmi_n), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    function automatic logic [31:0] ev(input int b);
        return 32'h0000_0001 << b;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic drive(input int p, input logic on);
        @(posedge sys_clk);
        case (p)
            0: reset_test_n <= !on;
            1: push_button_reset_n <= !on;
            2: host_reset_req <= on;
            3: uart_irq_request_n <= !on;
            4: nmi_test_n <= !on;
            default: host_nmi_req <= on;
        endcase
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        {rst_b, host_reset_req, host_nmi_req, bus_access_busy} = 4'h0;
        {reset_test_n, push_button_reset_n, uart_irq_request_n, nmi_test_n} = 4'hf;
        void'($urandom(28911));
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        wait_n(3);
        chk(32'(cpu_reset_n), 32'h0);
        wait_n(10);
        chk(32'(cpu_reset_n), 32'h1);
        brnc_cpu_model_inst.rd(`BRNC_ADDR_CTRL, rv);
        chk(rv, 32'h0000_0003);
        brnc_cpu_model_inst.rd(`BRNC_ADDR_IEN, rv);
        chk(rv, 32'h0000_0000);
        ien = 8'($urandom);
        brnc_cpu_model_inst.wr(`BRNC_ADDR_IEN, {24'($urandom), ien});
        brnc_cpu_model_inst.rd(`BRNC_ADDR_IEN, rv);
        chk(32'(rv[7:0]), 32'(ien));
        wait_n(1);
        chk(32'(irq), 32'(ien[7]));
        brnc_cpu_model_inst.rd(8'h10, rv);
        chk(rv, 32'h0000_0000);
        brnc_cpu_model_inst.wr(`BRNC_ADDR_STAT, 32'h0000_00ff);
        brnc_cpu_model_inst.wr(`BRNC_ADDR_IEN, 32'h0000_00ff);
        for (k = 0; k < 6; k++) begin
            sb = (k < 3) ? k + 4 : k - 3;
            // urgent sources start with the gate closed so the masked check means something
            brnc_cpu_model_inst.wr(`BRNC_ADDR_CTRL, (k < 3) ? 32'h0000_0002 : 32'h0000_0003);
            drive(k, 1'b1);
            wait_n(8);
            chk(32'(irq), 32'h1);
            if (k < 3) begin
                chk({cpu_reset_n, sys_reset_n}, 32'h0);
            end else begin
                chk(32'(cpu_nmi_n), 32'h1);
                brnc_cpu_model_inst.wr(`BRNC_ADDR_CTRL, 32'h0000_0002);
                wait_n(2);
                chk(32'(cpu_nmi_n), 32'h0);
                brnc_cpu_model_inst.service(rv);
                wait_n(2);
                chk(32'(cpu_nmi_n), 32'h1);
            end
            drive(k, 1'b0);
            wait_n(8);
            brnc_cpu_model_inst.rd(`BRNC_ADDR_STAT, rv);
            chk(rv & ev(sb), ev(sb));
            brnc_cpu_model_inst.rd(`BRNC_ADDR_CTRL, rv);
            chk(rv, 32'h0000_0003);
            brnc_cpu_model_inst.wr(`BRNC_ADDR_STAT, 32'h0000_00ff);
            brnc_cpu_model_inst.wr(`BRNC_ADDR_CTRL, 32'h0000_0002);
            wait_n(2);
            chk({cpu_reset_n, cpu_nmi_n, irq}, 32'h6);
        end
        chk(32'(brnc_cpu_model_inst.nmi_cnt), 32'h3);
        brnc_cpu_model_inst.wr(`BRNC_ADDR_CTRL, 32'h0000_0003);
        bus_access_busy <= 1'b1;
        wait_n(20 + $urandom % 6);
        bus_access_busy <= 1'b0;
        wait_n(4);
        chk(32'(bus_timeout_flag_n), 32'h1);
        bus_access_busy <= 1'b1;
        wait_n(40);
        bus_access_busy <= 1'b0;
        chk(32'(bus_timeout_flag_n), 32'h0);
        brnc_cpu_model_inst.wr(`BRNC_ADDR_CTRL, 32'h0000_0001);
        wait_n(4);
        chk(32'(bus_timeout_flag_n), 32'h0);
        brnc_cpu_model_inst.wr(`BRNC_ADDR_CTRL, 32'h0000_0003);
        wait_n(3);
        chk(32'(bus_timeout_flag_n), 32'h1);
        finish_test();
    end
endmodule

`default_nettype wire
